// ===== ltp_loop_model.sv
`timescale 1ns/1ps
module ltp_loop_model #(
  parameter int DLY = 500
) (
  input wire logic clk, // Module clock
  input wire logic tx_clk, // Clock into the link
  input wire logic tx_data, // Data into the link
  output logic rx_clk, // Clock back from the link
  output logic rx_data // Data back from the link
);
  // Error-free loop: a pure delay, so any timing error is the design's own
  logic [DLY-1:0] clk_r = '0;
  logic [DLY-1:0] dat_r = '0;
  always_ff @(posedge clk) begin
    clk_r <= {clk_r[DLY-2:0], tx_clk};
    dat_r <= {dat_r[DLY-2:0], tx_data};
  end
  assign rx_clk = clk_r[DLY-1];
  assign rx_data = dat_r[DLY-1];
endmodule // ltp_loop_model

// ===== ltp_pkg.sv
// Summary of operation
// - Frame length is words times bits per word
// - Sync pattern sent as upper then lower half
// - Repeat n re-sends previous loaded word n times
// - Frames up to 4096 words, with frame tally
// - Bit order setting selects MSB or LSB first
// - Send inserts one bit error, timing starts
// - Several timings are averaged before reporting
// - Internal and rate dependent latency is subtracted
// - Delay reported in tenths of a microsecond
// - Any received error ends the timing
// - Measurement starts only on the send command
// - Sweep runs single, sawtooth or cycle
// - Linear shape gives constant rate of change
// - Curve shape gives nonlinear rate of change
// - Start above end gives a descending sweep
// - Sweep period in seconds sets traversal time
// - Receiver continuously measures incoming bit rate
// - Up to 32 instructions, restarted each frame
// - Literal load sends the next slot's value
package ltp_pkg;
  localparam int CLK_HZ = 50_000_000;
  localparam int MS_PER_S = 1000;
  localparam int TENTH_US_HZ = 10_000_000;
  localparam int CYC_PER_TENTH = CLK_HZ / TENTH_US_HZ;
  localparam logic [63:0] RECIP_TENTH =
    64'(((64'd1 << 32) + 64'(CYC_PER_TENTH) - 64'd1) / 64'(CYC_PER_TENTH));
  localparam int INSTR_SLOTS = 32;
  localparam int MEAS_LOG2_DEF = 2;
  localparam logic [31:0] INT_LAT_CYC = 32'h0000_0004;
  localparam logic [5:0] SETTLE_BITS = 6'h20;
  localparam logic [14:0] PRBS_SEED = 15'h7FFF;
  // Register byte offsets
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_FORMAT = 8'h04;
  localparam logic [7:0] REG_SYNC = 8'h08;
  localparam logic [7:0] REG_SLOT_SEL = 8'h0C;
  localparam logic [7:0] REG_SLOT_VAL = 8'h10;
  localparam logic [7:0] REG_RATE_START = 8'h14;
  localparam logic [7:0] REG_RATE_END = 8'h18;
  localparam logic [7:0] REG_SWEEP_PERIOD = 8'h1C;
  localparam logic [7:0] REG_CMD = 8'h20;
  localparam logic [7:0] REG_LOOP_DELAY = 8'h24;
  localparam logic [7:0] REG_RX_RATE = 8'h28;
  localparam logic [7:0] REG_ERR_COUNT = 8'h2C;
  localparam logic [7:0] REG_CUR_RATE = 8'h30;
  // Field positions
  localparam int CTRL_PCM = 0;
  localparam int CTRL_MSB = 1;
  localparam int CTRL_SWEEP_EN = 2;
  localparam int CTRL_OP_LSB = 3;
  localparam int CTRL_SHAPE = 5;
  localparam int FMT_WPF_LSB = 16;
  localparam int CMD_SEND = 0;
  localparam int CMD_CLR = 1;
  // Reset values
  localparam logic [5:0] RST_CTRL = 6'h02;
  localparam logic [3:0] RST_BPW_M1 = 4'hF;
  localparam logic [11:0] RST_WPF_M1 = 12'h00F;
  localparam logic [31:0] RST_SYNC = 32'h0000_0000;
  localparam logic [31:0] RST_RATE = 32'h0100_0000;
  localparam logic [5:0] RST_PERIOD = 6'h01;

  typedef enum logic [1:0] {OP_SYNC = 2'h0, OP_IMM = 2'h1, OP_REP = 2'h2, OP_TALLY = 2'h3} ltp_op_t;
  typedef enum logic [1:0] {SW_SINGLE = 2'h0, SW_SAW = 2'h1, SW_CYCLE = 2'h2} ltp_sweep_op_t;
  typedef enum logic [1:0] {ST_DIV = 2'h0, ST_RUN = 2'h1, ST_HOLD = 2'h3} ltp_sw_st_t;
  typedef enum logic [1:0] {DL_IDLE = 2'h0, DL_ARM = 2'h1, DL_TIME = 2'h3, DL_SETTLE = 2'h2} ltp_dly_t;

  typedef struct packed {
    logic [1:0] op;
    logic [15:0] arg;
  } ltp_instr_t;

  typedef struct packed {
    logic en;
    logic curve;
    logic [1:0] op;
    logic [5:0] period_s;
    logic [31:0] rate_a;
    logic [31:0] rate_b;
  } ltp_sweep_cfg_t;
endpackage

// ===== ltp_rxrate.sv
`timescale 1ns/1ps
module ltp_rxrate import ltp_pkg::*; #(
  parameter int GATE_CYCLES = CLK_HZ
) (
  input wire logic clk, // Module clock
  input wire logic resetn, // Asynchronous reset, active low
  input wire logic rise, // One-cycle pulse per received clock rising edge
  output logic [31:0] rate_r // Edges counted in the last gate
);
  logic [31:0] gate_r;
  logic [31:0] cnt_r;
  logic gate_end;

  assign gate_end = (gate_r == 32'(GATE_CYCLES - 1));

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      gate_r <= 32'h0;
      cnt_r <= 32'h0;
      rate_r <= 32'h0;
    end else begin
      gate_r <= gate_end ? 32'h0 : gate_r + 32'h1;
      cnt_r <= gate_end ? 32'h0 : cnt_r + 32'(rise);
      if (gate_end) begin
        rate_r <= cnt_r + 32'(rise);
      end
    end
  end

  rate_latch_a: assert property (@(posedge clk) disable iff (!resetn)
    gate_end |=> rate_r == $past(cnt_r) + 32'($past(rise)))
    else $error("received rate not latched at gate end");
endmodule // ltp_rxrate

// ===== ltp_sweep.sv
`timescale 1ns/1ps
module ltp_sweep import ltp_pkg::*; #(
  parameter int MS_CYCLES = CLK_HZ / MS_PER_S
) (
  input wire logic clk, // Module clock
  input wire logic resetn, // Asynchronous reset, active low
  input wire ltp_sweep_cfg_t cfg, // Sweep settings
  input wire logic restart, // Reload settings and start over
  output logic half_tick_r, // Pulse at twice the bit rate
  output logic [31:0] rate_r // Current phase increment
);
  ltp_sw_st_t st_r;
  logic [31:0] ms_r, a_r, b_r, dvs, cfg_delta;
  logic [47:0] dvd_r, quo_r, cur_r, step;
  logic [32:0] rem_r, rem_sh;
  logic [5:0] div_i_r;
  logic [15:0] k_r, n_ticks, kmin;
  logic [31:0] phase_r;
  logic [32:0] phase_sum;
  logic ms_tick, up;

  assign ms_tick = (ms_r == 32'(MS_CYCLES - 1));
  assign n_ticks = 16'(32'(cfg.period_s) * MS_PER_S);
  // Curve divides by n squared so that the triangular profile sums to the full span
  assign dvs = cfg.curve ? 32'(n_ticks) * 32'(n_ticks) : 32'(n_ticks);
  assign cfg_delta = (cfg.rate_b >= cfg.rate_a) ? cfg.rate_b - cfg.rate_a
                                                : cfg.rate_a - cfg.rate_b;
  assign up = (b_r >= a_r);
  assign rem_sh = {rem_r[31:0], dvd_r[47]};
  assign kmin = (k_r < n_ticks - k_r) ? k_r : n_ticks - k_r;
  assign step = cfg.curve ? 48'(quo_r * 48'({kmin, 2'h0})) : quo_r;
  assign phase_sum = {1'b0, phase_r} + {1'b0, cur_r[47:16]};

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ms_r <= 32'h0;
    end else begin
      ms_r <= ms_tick ? 32'h0 : ms_r + 32'h1;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      st_r <= ST_DIV;
      a_r <= 32'h0;
      b_r <= 32'h0;
      cur_r <= 48'h0;
      k_r <= 16'h0;
      dvd_r <= 48'h0;
      quo_r <= 48'h0;
      rem_r <= 33'h0;
      div_i_r <= 6'h0;
    end else if (restart || !cfg.en) begin
      st_r <= ST_DIV;
      a_r <= cfg.rate_a;
      b_r <= cfg.rate_b;
      cur_r <= {cfg.rate_a, 16'h0};
      k_r <= 16'h0;
      dvd_r <= {cfg_delta, 16'h0};
      rem_r <= 33'h0;
      div_i_r <= 6'h0;
    end else begin
      case (st_r)
        ST_DIV: begin
          // Step per tick, 16 fractional bits, by one restoring division
          dvd_r <= {dvd_r[46:0], 1'b0};
          if (rem_sh >= {1'b0, dvs}) begin
            rem_r <= rem_sh - {1'b0, dvs};
            quo_r <= {quo_r[46:0], 1'b1};
          end else begin
            rem_r <= rem_sh;
            quo_r <= {quo_r[46:0], 1'b0};
          end
          div_i_r <= div_i_r + 6'h1;
          if (div_i_r == 6'd47) begin
            st_r <= ST_RUN;
          end
        end
        ST_RUN: begin
          if (ms_tick) begin
            if (k_r >= n_ticks) begin
              k_r <= 16'h0;
              case (cfg.op)
                SW_SINGLE: begin
                  cur_r <= {b_r, 16'h0};
                  st_r <= ST_HOLD;
                end
                SW_CYCLE: begin
                  cur_r <= {b_r, 16'h0};
                  a_r <= b_r;
                  b_r <= a_r;
                end
                default: cur_r <= {a_r, 16'h0};
              endcase
            end else begin
              cur_r <= up ? cur_r + step : cur_r - step;
              k_r <= k_r + 16'h1;
            end
          end
        end
        default: st_r <= ST_HOLD;
      endcase
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      phase_r <= 32'h0;
      half_tick_r <= 1'b0;
      rate_r <= 32'h0;
    end else begin
      phase_r <= phase_sum[31:0];
      half_tick_r <= phase_sum[32];
      rate_r <= cur_r[47:16];
    end
  end

  hold_stable_a: assert property (@(posedge clk) disable iff (!resetn)
    (st_r == ST_HOLD && !restart && cfg.en) |=> $stable(cur_r))
    else $error("single sweep did not hold its end rate");
  sweep_dir_a: assert property (@(posedge clk) disable iff (!resetn)
    (st_r == ST_RUN && ms_tick && k_r < n_ticks && !restart && cfg.en && !up)
      |=> cur_r == $past(cur_r) - $past(step))
    else $error("descending sweep did not step down");
endmodule // ltp_sweep

// ===== ltp_top.sv
`timescale 1ns/1ps
module ltp_top import ltp_pkg::*; #(
  parameter int MS_CYCLES = CLK_HZ / MS_PER_S,
  parameter int RX_GATE_CYCLES = CLK_HZ,
  parameter int SLOTS = INSTR_SLOTS,
  parameter int MEAS_LOG2 = MEAS_LOG2_DEF
) (
  input wire logic clk, // Module clock, 50 MHz
  input wire logic resetn, // Asynchronous reset, active low
  input wire logic [7:0] addr, // Register byte address
  input wire logic [31:0] wr_data, // Register write data
  input wire logic wr_en, // Write strobe
  input wire logic rd_en, // Read strobe
  output logic [31:0] rd_data_r, // Read data, cycle after the strobe
  output logic tx_clk_r, // Serial transmit clock
  output logic tx_data_r, // Serial transmit data
  input wire logic rx_clk, // Looped-back receive clock
  input wire logic rx_data // Looped-back receive data
);
  localparam int PCW = $clog2(SLOTS);
  localparam int NMEAS = 1 << MEAS_LOG2;

  logic [5:0] ctrl_r, period_r;
  logic [3:0] bpw_m1_r;
  logic [11:0] wpf_m1_r;
  logic [31:0] sync_r, rate_a_r, rate_b_r;
  logic [PCW-1:0] sel_r;
  ltp_instr_t mem_r [SLOTS];
  logic pcm, msb, send, clr, sweep_restart_r, gen_restart;
  logic [31:0] rd_mux;

  assign pcm = ctrl_r[CTRL_PCM];
  assign msb = ctrl_r[CTRL_MSB];
  assign send = wr_en && addr == REG_CMD && wr_data[CMD_SEND];
  assign clr = wr_en && addr == REG_CMD && wr_data[CMD_CLR];
  assign gen_restart = wr_en && (addr == REG_FORMAT || addr == REG_CTRL);

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ctrl_r <= RST_CTRL;
      bpw_m1_r <= RST_BPW_M1;
      wpf_m1_r <= RST_WPF_M1;
      sync_r <= RST_SYNC;
      rate_a_r <= RST_RATE;
      rate_b_r <= RST_RATE;
      period_r <= RST_PERIOD;
      sel_r <= '0;
    end else if (wr_en) begin
      if (addr == REG_CTRL) begin
        ctrl_r <= wr_data[5:0];
      end else if (addr == REG_FORMAT) begin
        bpw_m1_r <= wr_data[3:0];
        wpf_m1_r <= wr_data[FMT_WPF_LSB +: 12];
      end else if (addr == REG_SYNC) begin
        sync_r <= wr_data;
      end else if (addr == REG_SLOT_SEL) begin
        sel_r <= wr_data[PCW-1:0];
      end else if (addr == REG_RATE_START) begin
        rate_a_r <= wr_data;
      end else if (addr == REG_RATE_END) begin
        rate_b_r <= wr_data;
      end else if (addr == REG_SWEEP_PERIOD) begin
        period_r <= wr_data[5:0];
      end
    end
  end

  // Instruction store; no reset so it maps onto plain flops without a clear tree
  always_ff @(posedge clk) begin
    if (wr_en && addr == REG_SLOT_VAL) begin
      mem_r[sel_r] <= wr_data[17:0];
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      sweep_restart_r <= 1'b0;
    end else begin
      sweep_restart_r <= wr_en && (addr == REG_CTRL || addr == REG_RATE_START ||
                         addr == REG_RATE_END || addr == REG_SWEEP_PERIOD);
    end
  end

  // Sweep and transmit clock
  logic half_tick, launch;
  logic [31:0] cur_rate;
  ltp_sweep_cfg_t sweep_cfg;

  assign sweep_cfg = '{en: ctrl_r[CTRL_SWEEP_EN], curve: ctrl_r[CTRL_SHAPE],
                       op: ctrl_r[CTRL_OP_LSB +: 2], period_s: period_r,
                       rate_a: rate_a_r, rate_b: rate_b_r};

  ltp_sweep #(.MS_CYCLES(MS_CYCLES)) u_sweep (
    .clk(clk),
    .resetn(resetn),
    .cfg(sweep_cfg),
    .restart(sweep_restart_r),
    .half_tick_r(half_tick),
    .rate_r(cur_rate)
  );

  // Data changes on the falling edge so the far end samples mid-bit
  assign launch = half_tick && tx_clk_r;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      tx_clk_r <= 1'b0;
    end else if (half_tick) begin
      tx_clk_r <= ~tx_clk_r;
    end
  end

  // Frame word generator
  logic [PCW-1:0] pc_r, pc_nxt;
  logic [15:0] rep_r, rep_nxt, last_r, word_r, tally_r, fw, cur_word;
  logic [11:0] widx_r;
  logic [3:0] bit_idx_r, pos;
  logic half_r, half_nxt, word_load, pcm_bit;
  ltp_instr_t ins, ins_next;

  assign ins = mem_r[pc_r];
  assign ins_next = mem_r[PCW'(pc_r + 1'b1)];

  always_comb begin
    fw = last_r;
    pc_nxt = pc_r;
    rep_nxt = rep_r;
    half_nxt = half_r;
    if (rep_r != 16'h0) begin
      rep_nxt = rep_r - 16'h1;
    end else begin
      case (ins.op)
        OP_SYNC: begin
          // Short words take the top bits of each half
          fw = (half_r ? sync_r[15:0] : sync_r[31:16]) >> (4'hF - bpw_m1_r);
          half_nxt = ~half_r;
          pc_nxt = PCW'(pc_r + 1'b1);
        end
        OP_IMM: begin
          fw = ins_next.arg;
          pc_nxt = PCW'(pc_r + 2'h2);
        end
        OP_REP: begin
          rep_nxt = (ins.arg == 16'h0) ? 16'h0 : ins.arg - 16'h1;
          pc_nxt = PCW'(pc_r + 1'b1);
        end
        default: begin
          fw = tally_r;
          pc_nxt = PCW'(pc_r + 1'b1);
        end
      endcase
    end
  end

  assign word_load = launch && pcm && bit_idx_r == 4'h0;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pc_r <= '0;
      rep_r <= 16'h0;
      half_r <= 1'b0;
      widx_r <= 12'h0;
      tally_r <= 16'h0;
      last_r <= 16'h0;
      word_r <= 16'h0;
    end else if (gen_restart) begin
      pc_r <= '0;
      rep_r <= 16'h0;
      half_r <= 1'b0;
      widx_r <= 12'h0;
    end else if (word_load) begin
      word_r <= fw;
      last_r <= fw;
      if (widx_r == wpf_m1_r) begin
        widx_r <= 12'h0;
        pc_r <= '0;
        rep_r <= 16'h0;
        half_r <= 1'b0;
        tally_r <= tally_r + 16'h1;
      end else begin
        widx_r <= widx_r + 12'h1;
        pc_r <= pc_nxt;
        rep_r <= rep_nxt;
        half_r <= half_nxt;
      end
    end
  end

  // Serializer and pseudo-random source
  logic [14:0] prbs_r;
  logic prbs_bit, inj;
  ltp_dly_t dly_r;

  assign cur_word = (bit_idx_r == 4'h0) ? fw : word_r;
  assign pos = msb ? bpw_m1_r - bit_idx_r : bit_idx_r;
  assign pcm_bit = cur_word[pos];
  assign prbs_bit = prbs_r[14] ^ prbs_r[13];
  assign inj = (dly_r == DL_ARM);

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      bit_idx_r <= 4'h0;
      prbs_r <= PRBS_SEED;
      tx_data_r <= 1'b0;
    end else if (gen_restart) begin
      bit_idx_r <= 4'h0;
    end else if (launch) begin
      if (pcm) begin
        bit_idx_r <= (bit_idx_r == bpw_m1_r) ? 4'h0 : bit_idx_r + 4'h1;
      end else begin
        prbs_r <= {prbs_r[13:0], prbs_bit};
      end
      tx_data_r <= (pcm ? pcm_bit : prbs_bit) ^ inj;
    end
  end

  // Bit period in clocks, for the rate-dependent latency
  logic [31:0] per_cnt_r, bit_per_r;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      per_cnt_r <= 32'h0;
      bit_per_r <= 32'h0;
    end else if (launch) begin
      per_cnt_r <= 32'h0;
      bit_per_r <= per_cnt_r + 32'h1;
    end else begin
      per_cnt_r <= per_cnt_r + 32'h1;
    end
  end

  // Receive side
  logic rxc_s1_r, rxc_s2_r, rxc_s3_r, rxd_s1_r, rxd_s2_r, rx_rise, err_evt_r;
  logic [14:0] rx_sh_r;
  logic [31:0] err_cnt_r, rx_rate;

  assign rx_rise = rxc_s2_r && !rxc_s3_r;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rxc_s1_r <= 1'b0;
      rxc_s2_r <= 1'b0;
      rxc_s3_r <= 1'b0;
      rxd_s1_r <= 1'b0;
      rxd_s2_r <= 1'b0;
    end else begin
      rxc_s1_r <= rx_clk;
      rxc_s2_r <= rxc_s1_r;
      rxc_s3_r <= rxc_s2_r;
      rxd_s1_r <= rx_data;
      rxd_s2_r <= rxd_s1_r;
    end
  end

  // Self-synchronising check: one flipped bit shows as three errors
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rx_sh_r <= 15'h0;
      err_evt_r <= 1'b0;
      err_cnt_r <= 32'h0;
    end else begin
      err_evt_r <= rx_rise && !pcm && (rxd_s2_r ^ rx_sh_r[14] ^ rx_sh_r[13]);
      if (rx_rise) begin
        rx_sh_r <= {rx_sh_r[13:0], rxd_s2_r};
      end
      if (err_evt_r) begin
        err_cnt_r <= clr ? 32'h1 : err_cnt_r + 32'h1;
      end else if (clr) begin
        err_cnt_r <= 32'h0;
      end
    end
  end

  ltp_rxrate #(.GATE_CYCLES(RX_GATE_CYCLES)) u_rxrate (
    .clk(clk),
    .resetn(resetn),
    .rise(rx_rise),
    .rate_r(rx_rate)
  );

  // Loop delay measurement
  logic [31:0] tcnt_r, lat, delay_r, avg;
  logic [31+MEAS_LOG2:0] sum_r;
  logic [MEAS_LOG2:0] idx_r;
  logic [5:0] settle_r;
  logic valid_r;

  assign lat = {1'b0, bit_per_r[31:1]} + INT_LAT_CYC;
  assign avg = sum_r[MEAS_LOG2 +: 32];

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      dly_r <= DL_IDLE;
      tcnt_r <= 32'h0;
      sum_r <= '0;
      idx_r <= '0;
      settle_r <= 6'h0;
      delay_r <= 32'h0;
      valid_r <= 1'b0;
    end else begin
      case (dly_r)
        DL_IDLE: begin
          if (send && !pcm) begin
            dly_r <= DL_ARM;
            sum_r <= '0;
            idx_r <= '0;
            valid_r <= 1'b0;
          end
        end
        DL_ARM: begin
          // A register restart swallows that launch, so wait for one that really sends
          if (launch && !gen_restart) begin
            dly_r <= DL_TIME;
            tcnt_r <= 32'h0;
          end
        end
        DL_TIME: begin
          tcnt_r <= tcnt_r + 32'h1;
          if (err_evt_r) begin
            sum_r <= sum_r + ((tcnt_r > lat) ? (32+MEAS_LOG2)'(tcnt_r - lat) : '0);
            settle_r <= 6'h0;
            dly_r <= DL_SETTLE;
          end else if (tcnt_r == 32'hFFFF_FFFF) begin
            dly_r <= DL_IDLE;
          end
        end
        default: begin
          if (rx_rise) begin
            settle_r <= settle_r + 6'h1;
            if (settle_r == SETTLE_BITS - 6'h1) begin
              if (idx_r == (MEAS_LOG2 + 1)'(NMEAS - 1)) begin
                dly_r <= DL_IDLE;
                valid_r <= 1'b1;
                delay_r <= 32'((64'(avg) * RECIP_TENTH) >> 32);
              end else begin
                idx_r <= idx_r + 1'b1;
                dly_r <= DL_ARM;
              end
            end
          end
        end
      endcase
    end
  end

  // Register read port
  always_comb begin
    rd_mux = 32'h0;
    if (addr == REG_CTRL) begin
      rd_mux = 32'(ctrl_r);
    end else if (addr == REG_FORMAT) begin
      rd_mux = {4'h0, wpf_m1_r, 12'h0, bpw_m1_r};
    end else if (addr == REG_SYNC) begin
      rd_mux = sync_r;
    end else if (addr == REG_SLOT_SEL) begin
      rd_mux = 32'(sel_r);
    end else if (addr == REG_SLOT_VAL) begin
      rd_mux = 32'(mem_r[sel_r]);
    end else if (addr == REG_RATE_START) begin
      rd_mux = rate_a_r;
    end else if (addr == REG_RATE_END) begin
      rd_mux = rate_b_r;
    end else if (addr == REG_SWEEP_PERIOD) begin
      rd_mux = 32'(period_r);
    end else if (addr == REG_CMD) begin
      rd_mux = {30'h0, valid_r, dly_r != DL_IDLE};
    end else if (addr == REG_LOOP_DELAY) begin
      rd_mux = delay_r;
    end else if (addr == REG_RX_RATE) begin
      rd_mux = rx_rate;
    end else if (addr == REG_ERR_COUNT) begin
      rd_mux = err_cnt_r;
    end else if (addr == REG_CUR_RATE) begin
      rd_mux = cur_rate;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rd_data_r <= 32'h0;
    end else begin
      rd_data_r <= rd_en ? rd_mux : 32'h0;
    end
  end

  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);

  sequence arm_launch_s;
    dly_r == DL_ARM && launch && !gen_restart;
  endsequence
  sequence timing_s;
    dly_r == DL_TIME;
  endsequence

  frame_wrap_a: assert property (
    (word_load && !gen_restart && widx_r == wpf_m1_r) |=> widx_r == 12'h0 && pc_r == '0)
    else $error("frame did not restart after last word");
  sync_first_a: assert property (
    (rep_r == 16'h0 && ins.op == OP_SYNC && !half_r && bpw_m1_r == 4'hF)
      |-> fw == sync_r[31:16])
    else $error("upper sync half not sent first");
  repeat_word_a: assert property ((rep_r != 16'h0) |-> fw == last_r)
    else $error("repeat did not resend previous word");
  bit_order_a: assert property (
    (launch && pcm && !inj && !gen_restart && bit_idx_r == 4'h0)
      |=> tx_data_r == $past(fw[msb ? bpw_m1_r : 4'h0]))
    else $error("first serial bit has wrong order");
  inject_one_a: assert property (
    arm_launch_s |=> timing_s ##0 tx_data_r == $past(~prbs_bit))
    else $error("error bit not inserted at start of timing");
  err_stop_a: assert property ((timing_s ##0 err_evt_r) |=> dly_r == DL_SETTLE)
    else $error("received error did not end timing");
  send_only_a: assert property ((dly_r == DL_IDLE && !send) |=> dly_r == DL_IDLE)
    else $error("measurement began without send");
  latency_sub_a: assert property (
    (timing_s ##0 err_evt_r && tcnt_r > lat)
      |=> sum_r == $past(sum_r) + (32+MEAS_LOG2)'($past(tcnt_r) - $past(lat)))
    else $error("internal latency not subtracted");
endmodule // ltp_top

// ===== tb_link_test_pattern_delay_sweep.sv
`timescale 1ns/1ps
module tb_link_test_pattern_delay_sweep import ltp_pkg::*;;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [31:0] wr_data = 32'h0;
  logic wr_en = 1'b0;
  logic rd_en = 1'b0;
  logic [31:0] rd_data_r;
  logic tx_clk_r, tx_data_r, rx_clk, rx_data;
  int err_count = 0;
  int check_count = 0;
  logic [31:0] v;
  logic [31:0] rnd;
  logic [15:0] exp_q[$];
  int prog [10] = '{18'h00000, 18'h00000, 18'h10000, 18'h00000, 18'h20007,
                    18'h10000, 18'h01248, 18'h10000, 18'h00000, 18'h20004};
  ltp_top #(.MS_CYCLES(20), .RX_GATE_CYCLES(1000), .SLOTS(32), .MEAS_LOG2(2)) uut (
    .clk(clk), .resetn(resetn), .addr(addr), .wr_data(wr_data), .wr_en(wr_en),
    .rd_en(rd_en), .rd_data_r(rd_data_r), .tx_clk_r(tx_clk_r), .tx_data_r(tx_data_r),
    .rx_clk(rx_clk), .rx_data(rx_data));
  ltp_loop_model #(.DLY(500)) loop_i (.clk(clk), .tx_clk(tx_clk_r), .tx_data(tx_data_r),
    .rx_clk(rx_clk), .rx_data(rx_data));
  initial begin
    forever #10 clk = ~clk;
  end
  task automatic wrap_up();
    $display("checks %0d errors %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] lo, input logic [31:0] hi);
    check_count++;
    if (((got >= lo) && (got <= hi)) !== 1'b1) begin
      err_count++;
      $display("wrong value at %0t: got %h want %h..%h", $time, got, lo, hi);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wr_data <= d;
    wr_en <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    #1 v = rd_data_r;
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    rd(a);
    chk(v, e, e);
  endtask
  // Reference model: runs the instruction list to give one frame's words
  task automatic build_frame();
    int pc;
    int n;
    bit half;
    logic [15:0] last;
    exp_q = {};
    pc = 0;
    half = 1'b0;
    last = 16'h0;
    while (exp_q.size() < 16) begin
      n = 1;
      if (prog[pc][17:16] == 2'h0) begin
        last = half ? 16'h3400 : 16'hFAF3;
        half = !half;
      end else if (prog[pc][17:16] == 2'h1) begin
        pc++;
        last = prog[pc][15:0];
      end else begin
        n = prog[pc][15:0];
      end
      repeat (n) exp_q.push_back(last);
      pc++;
    end
  endtask
  // Hunt for the upper sync half, then walk the other 15 words bit by bit
  task automatic pcm_run(input logic msb);
    logic [15:0] w;
    logic [15:0] s;
    logic [15:0] e;
    int n;
    wr(REG_CTRL, {30'h0, msb, 1'b1});
    build_frame();
    s = exp_q[0];
    if (!msb) s = {<<{exp_q[0]}};
    w = 16'h0;
    n = 0;
    while (w !== s && n < 1000) begin
      @(posedge tx_clk_r);
      w = {w[14:0], tx_data_r};
      n++;
    end
    chk(n, 16, 999);
    for (int i = 1; i < 16; i++) begin
      e = exp_q[i];
      for (int b = 0; b < 16; b++) begin
        @(posedge tx_clk_r);
        chk(tx_data_r, e[msb ? 15 - b : b], e[msb ? 15 - b : b]);
      end
    end
  endtask
  initial begin
    void'($urandom(32'h578B47B7));
    repeat (20) @(posedge clk);
    resetn <= 1'b1;
    rdc(REG_CTRL, 32'h0000_0002);
    rdc(REG_FORMAT, 32'h000F_000F);
    rdc(REG_RATE_START, 32'h0100_0000);
    rdc(REG_SWEEP_PERIOD, 32'h0000_0001);
    rdc(8'h3C, 32'h0);
    rnd = $urandom();
    wr(REG_SYNC, rnd);
    rdc(REG_SYNC, rnd);
    wr(REG_SYNC, 32'hFAF3_3400);
    // Half tick every 4 clocks: a 160 ns link clock
    wr(REG_RATE_START, 32'h4000_0000);
    for (int i = 0; i < 10; i++) begin
      wr(REG_SLOT_SEL, i);
      wr(REG_SLOT_VAL, prog[i]);
    end
    pcm_run(1'b1);
    pcm_run(1'b0);
    wr(REG_CMD, 32'h1);
    rdc(REG_CMD, 32'h0);
    wr(REG_CTRL, 32'h0);
    repeat (3000) @(posedge clk);
    wr(REG_CMD, 32'h2);
    rdc(REG_ERR_COUNT, 32'h0);
    wr(REG_CMD, 32'h1);
    v = 32'h0;
    for (int k = 0; k < 400 && v[1] !== 1'b1; k++) begin
      repeat (40) @(posedge clk);
      rd(REG_CMD);
    end
    chk(v, 2, 2);
    rd(REG_LOOP_DELAY);
    chk(v, 99, 101);
    rd(REG_RX_RATE);
    chk(v, 125, 125);
    wr(REG_RATE_END, 32'h1000_0000);
    wr(REG_CTRL, 32'h4);
    repeat (10000) @(posedge clk);
    rd(REG_CUR_RATE);
    chk(v, 32'h2700_0000, 32'h2900_0000);
    repeat (15000) @(posedge clk);
    rdc(REG_CUR_RATE, 32'h1000_0000);
    // A quarter into a curved leg only an eighth of the span is covered
    wr(REG_CTRL, 32'h34);
    repeat (5000) @(posedge clk);
    rd(REG_CUR_RATE);
    chk(v, 32'h3900_0000, 32'h3B00_0000);
    repeat (20000) @(posedge clk);
    rd(REG_CUR_RATE);
    chk(v, 32'h1400_0000, 32'h1700_0000);
    wrap_up();
  end
  initial begin
    #1_800_000;
    err_count++;
    wrap_up();
  end
endmodule // tb_link_test_pattern_delay_sweep
